// *** design/msc_misc_top.sv ***
// user pins, mode bits, chain handshake and interrupt of the block
// assumes a single-cycle register port driven on sys_clk
//
// Chosen here: strobed register access and the register offsets.
`timescale 1ns/1ns
module msc_misc_top
	import msc_pkg::*;
(
	input  wire logic              sys_clk,
	input  wire logic              rst_n,
	input  wire logic [ADDR_W-1:0] regAddr,
	input  wire logic [DATA_W-1:0] wrData,
	input  wire logic              wrEn,
	input  wire logic              rdEn,
	output logic      [DATA_W-1:0] rdData,
	input  wire logic [SENSE_W-1:0] senseIn,
	output logic                   enableOut0,
	output logic                   enableOut1,
	output logic                   runMode,
	output logic                   chainMode,
	input  wire logic              startDelim,
	input  wire logic              chainStart,
	input  wire logic              crIn,
	output logic                   crOut,
	output logic                   crOe,
	output logic                   irq
);

	// ********************************
	// state
	// ********************************
	typedef struct packed {
		logic [SENSE_W-1:0] sense;
		logic               en0;
		logic               en1;
		logic               run;
		logic               chain;
		msc_chain_e         chainSt;
		logic [INT_W-1:0]   intStat;
		logic [INT_W-1:0]   intEn;
		logic               irq;
		logic [DATA_W-1:0]  rdData;
		logic               csS1;
		logic               csS2;
		logic               csPrev;
		logic               crS1;
		logic               crS2;
		logic               crOe;
		logic               crOut;
	} msc_core_s;

	localparam msc_core_s CORE_RST = '{
		sense:   '0,
		en0:     1'b0,
		en1:     1'b0,
		run:     1'b0,
		chain:   1'b0,
		chainSt: CH_OFF,
		intStat: '0,
		intEn:   '0,
		irq:     1'b0,
		rdData:  '0,
		csS1:    1'b0,
		csS2:    1'b0,
		csPrev:  1'b0,
		crS1:    1'b0,
		crS2:    1'b0,
		crOe:    1'b1,
		crOut:   1'b0
	};

	msc_core_s          st_reg;
	msc_core_s          st_next;
	logic [INT_W-1:0]   events;
	logic [INT_W-1:0]   intClr;
	logic               updUpr;
	logic               updMode;

	msc_sense_if sif ();

	assign sif.raw = senseIn;

	msc_sense_filter uFilt (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.sif     (sif)
	);

	// ********************************
	// address decode
	// ********************************
	function automatic logic isReg(
		input logic [ADDR_W-1:0] a,
		input logic [ADDR_W-1:0] off
	);
		isReg = (a == off);
	endfunction : isReg

	assign updUpr  = wrEn && isReg(regAddr, OFF_UPR);
	assign updMode = wrEn && isReg(regAddr, OFF_MODE);

	// ********************************
	// next state
	// ********************************
	always_comb begin
		st_next = st_reg;
		events  = '0;
		intClr  = '0;

		// chain start and line level are pins: two flops first
		st_next.csS1   = chainStart;
		st_next.csS2   = st_reg.csS1;
		st_next.csPrev = st_reg.csS2;
		st_next.crS1   = crIn;
		st_next.crS2   = st_reg.crS1;

		if (updUpr) begin
			st_next.sense = st_reg.sense & ~wrData[SENSE_W-1:0];
			st_next.en0 = wrData[UPR_EN0];
			st_next.en1 = wrData[UPR_EN1];
		end
		st_next.sense = st_next.sense | sif.hit;

		if (updMode) begin
			st_next.run   = wrData[MODE_RUN];
			st_next.chain = wrData[MODE_CHAIN];
		end

		case (st_reg.chainSt)
			CH_OFF: begin
				if (st_next.chain) begin
					st_next.chainSt = CH_WAIT;
				end
			end
			CH_WAIT: begin
				if (!st_next.chain) begin
					st_next.chainSt = CH_OFF;
				end else if (startDelim) begin
					st_next.chainSt = CH_READY;
				end
			end
			CH_READY: begin
				if (!st_next.chain) begin
					st_next.chainSt = CH_OFF;
				end
			end
			default: begin
				st_next.chainSt = CH_OFF;
			end
		endcase
		st_next.crOe  = (st_next.chainSt != CH_READY);
		st_next.crOut = 1'b0;

		// events set sticky status; set beats a clear in one cycle
		events[INT_SENSE0] = sif.hit[UPR_SENSE0];
		events[INT_SENSE1] = sif.hit[UPR_SENSE1];
		events[INT_CRREL]  = (st_reg.chainSt == CH_WAIT) &&
			(st_next.chainSt == CH_READY);
		events[INT_CSTART] = st_reg.csS2 && !st_reg.csPrev;
		if (wrEn && isReg(regAddr, OFF_INT_CLR)) begin
			intClr = wrData[INT_W-1:0];
		end
		st_next.intStat = (st_reg.intStat & ~intClr) | events;
		if (wrEn && isReg(regAddr, OFF_INT_EN)) begin
			st_next.intEn = wrData[INT_W-1:0];
		end
		st_next.irq = |(st_next.intStat & st_next.intEn);

		// read data valid only in the cycle after the strobe
		st_next.rdData = '0;
		if (rdEn) begin
			case (regAddr)
				OFF_UPR: begin
					st_next.rdData[SENSE_W-1:0] = st_reg.sense;
					st_next.rdData[UPR_EN0]     = st_reg.en0;
					st_next.rdData[UPR_EN1]     = st_reg.en1;
				end
				OFF_MODE: begin
					st_next.rdData[MODE_RUN]   = st_reg.run;
					st_next.rdData[MODE_CHAIN] = st_reg.chain;
					st_next.rdData[MODE_READY] =
						(st_reg.chainSt == CH_READY);
					st_next.rdData[MODE_LINE]  = st_reg.crS2;
				end
				OFF_INT_STAT: begin
					st_next.rdData[INT_W-1:0] = st_reg.intStat;
				end
				OFF_INT_EN: begin
					st_next.rdData[INT_W-1:0] = st_reg.intEn;
				end
				default: begin
					st_next.rdData = '0;
				end
			endcase
		end
	end

	// ********************************
	// registers
	// ********************************
	// one clock, reset loads CORE_RST
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_reg <= CORE_RST;
		end else begin
			st_reg <= st_next;
		end
	end

	assign rdData     = st_reg.rdData;
	assign enableOut0 = st_reg.en0;
	assign enableOut1 = st_reg.en1;
	assign runMode    = st_reg.run;
	assign chainMode  = st_reg.chain;
	assign crOut      = st_reg.crOut;
	assign crOe       = st_reg.crOe;
	assign irq        = st_reg.irq;

	// ********************************
	// checks
	// ********************************
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	sequence sWrUpr;
		updUpr;
	endsequence

	sequence sRdStat;
		rdEn && isReg(regAddr, OFF_INT_STAT);
	endsequence

	a_reset_clears_all : assert property (
		$rose(rst_n) |-> st_reg == CORE_RST)
		else $error("register not cleared by reset");

	a_reset_stop_mode : assert property (
		$rose(rst_n) |-> !runMode && !chainMode)
		else $error("mode bit 0 not zero after reset");

	a_sense_sets_bit : assert property (
		sif.hit[UPR_SENSE0] |=> st_reg.sense[UPR_SENSE0] ##1
			st_reg.intStat[INT_SENSE0] || $past(intClr[INT_SENSE0]))
		else $error("sense bit 0 not set by sense input");

	a_sense_sticky : assert property (
		st_reg.sense[UPR_SENSE1] &&
			!(updUpr && wrData[UPR_SENSE1])
		|=> st_reg.sense[UPR_SENSE1])
		else $error("sense bit 1 lost without a clearing write");

	a_enable0_follow : assert property (
		sWrUpr |=> enableOut0 == $past(wrData[UPR_EN0]))
		else $error("enable output 0 differs from written bit");

	a_enable0_hold : assert property (
		!updUpr |=> $stable(enableOut0))
		else $error("enable output 0 moved without a write");

	a_enable1_follow : assert property (
		sWrUpr |=> enableOut1 == $past(wrData[UPR_EN1]))
		else $error("enable output 1 differs from written bit");

	a_chain_release : assert property (
		$fell(crOe) |-> chainMode && $past(startDelim) &&
			$past(chainMode))
		else $error("chain ready released without cause");

	a_chain_held : assert property (
		!chainMode |-> crOe && !crOut)
		else $error("chain ready not driven low");

	a_start_sampled : assert property (
		$rose(chainStart) ##1 chainStart |-> ##2
			st_reg.intStat[INT_CSTART])
		else $error("chain start event not recorded");

	a_read_latency : assert property (
		sRdStat |=> rdData[INT_W-1:0] == $past(st_reg.intStat))
		else $error("status read data wrong or late");

	a_read_idle : assert property (
		!rdEn |=> rdData == '0)
		else $error("read data not zero outside a read");

	a_enable1_hold : assert property (
		!updUpr |=> $stable(enableOut1))
		else $error("enable output 1 moved without a write");

	a_sense1_sets : assert property (
		sif.hit[UPR_SENSE1] |=> st_reg.sense[UPR_SENSE1] &&
			st_reg.intStat[INT_SENSE1])
		else $error("sense bit 1 not set by sense input");

	a_sense0_sticky : assert property (
		st_reg.sense[UPR_SENSE0] &&
			!(updUpr && wrData[UPR_SENSE0])
		|=> st_reg.sense[UPR_SENSE0])
		else $error("sense bit 0 lost without a clearing write");

	a_irq_level : assert property (
		irq == |(st_reg.intStat & st_reg.intEn))
		else $error("interrupt level differs from enabled status");

	a_mode_hold : assert property (
		!updMode |=> $stable(runMode) && $stable(chainMode))
		else $error("mode bits moved without a write");

	a_mode_follow : assert property (
		updMode |=> runMode == $past(wrData[MODE_RUN]) &&
			chainMode == $past(wrData[MODE_CHAIN]))
		else $error("mode bits differ from written value");

	// chain mode set, still pulling low, delimiter now, no mode clear
	sequence sDelimInWait;
		chainMode && crOe && startDelim &&
			!(updMode && !wrData[MODE_CHAIN]);
	endsequence

	a_delim_releases : assert property (
		sDelimInWait |=> !crOe)
		else $error("chain ready not released after delimiter");

	a_release_stands : assert property (
		!crOe && !(updMode && !wrData[MODE_CHAIN]) |=> !crOe)
		else $error("chain ready taken back without a mode write");

endmodule : msc_misc_top

// *** common/msc_pkg.sv ***
// constants, state codes and register map of the miscellaneous block
// assumes one clock, sys_clk at 25 MHz, and an active-low async reset
//
// How it works
// - reset clears every register to its reset state
// - reset forces mode bit 0 low, so the block sits in stop mode
// - a sense input high for 160 ns sets its sense bit
// - sense bits stay set until software clears them by a write
// - enable output 0 follows enable bit 0, bit two of user pins
// - enable output 1 follows enable bit 1, placed at bit three
// - chain ready released only with chain mode set and delimiter seen
// - all logic samples and drives on the one byte clock
package msc_pkg;

	// ********************************
	// bus and field layout
	// ********************************
	localparam int DATA_W   = 8;
	localparam int ADDR_W   = 4;
	localparam int SENSE_W  = 2;
	localparam int INT_W    = 4;
	localparam int CNT_W    = 3;

	localparam logic [ADDR_W-1:0] OFF_UPR      = 4'h0;
	localparam logic [ADDR_W-1:0] OFF_MODE     = 4'h1;
	localparam logic [ADDR_W-1:0] OFF_INT_STAT = 4'h2;
	localparam logic [ADDR_W-1:0] OFF_INT_CLR  = 4'h3;
	localparam logic [ADDR_W-1:0] OFF_INT_EN   = 4'h4;

	localparam int UPR_SENSE0  = 0;
	localparam int UPR_SENSE1  = 1;
	localparam int UPR_EN0     = 2;
	localparam int UPR_EN1     = 3;
	localparam int MODE_RUN    = 0;
	localparam int MODE_CHAIN  = 1;
	localparam int MODE_READY  = 2;
	localparam int MODE_LINE   = 7;

	localparam int INT_SENSE0  = 0;
	localparam int INT_SENSE1  = 1;
	localparam int INT_CRREL   = 2;
	localparam int INT_CSTART  = 3;

	// ********************************
	// timing
	// ********************************
	localparam int CLK_PERIOD_NS = 40;
	localparam int SENSE_MIN_NS  = 160;
	localparam int RST_MIN_NS    = 160;
	localparam int RST_WAIT_NS   = 960;
	localparam int SENSE_CYC     =
		(SENSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RST_MIN_CYC   =
		(RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RST_WAIT_CYC  =
		(RST_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [CNT_W-1:0] SENSE_LAST = CNT_W'(SENSE_CYC - 1);
	localparam logic [CNT_W-1:0] SENSE_FULL = CNT_W'(SENSE_CYC);

	// ********************************
	// chain handshake states
	// ********************************
	typedef enum logic [2:0] {
		CH_OFF   = 3'b001,
		CH_WAIT  = 3'b010,
		CH_READY = 3'b100
	} msc_chain_e;

endpackage : msc_pkg

// *** common/msc_sense_if.sv ***
// carrier between the sense filter and the core of the block
// assumes both ends run on the same clock
`timescale 1ns/1ns
interface msc_sense_if;
	import msc_pkg::*;
	logic [SENSE_W-1:0] raw;
	logic [SENSE_W-1:0] hit;
	modport filt (input raw, output hit);
	modport core (output raw, input hit);
endinterface : msc_sense_if

// *** design/msc_sense_filter.sv ***
// two-stage synchroniser and width filter for the sense inputs
// assumes raw pins are asynchronous to sys_clk
`timescale 1ns/1ns
module msc_sense_filter
	import msc_pkg::*;
(
	input  wire logic  sys_clk,
	input  wire logic  rst_n,
	msc_sense_if.filt  sif
);

	typedef struct packed {
		logic [SENSE_W-1:0]            s1;
		logic [SENSE_W-1:0]            s2;
		logic [SENSE_W-1:0][CNT_W-1:0] cnt;
		logic [SENSE_W-1:0]            hit;
	} msc_filt_s;

	msc_filt_s st_reg;
	msc_filt_s st_next;

	always_comb begin
		st_next = st_reg;
		st_next.s1 = sif.raw;
		st_next.s2 = st_reg.s1;
		for (int i = 0; i < SENSE_W; i++) begin
			st_next.hit[i] = 1'b0;
			if (st_reg.s2[i]) begin
				if (st_reg.cnt[i] == SENSE_LAST) begin
					st_next.hit[i] = 1'b1;
				end
				if (st_reg.cnt[i] != SENSE_FULL) begin
					st_next.cnt[i] = st_reg.cnt[i] + CNT_W'(1);
				end
			end else begin
				st_next.cnt[i] = '0;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign sif.hit = st_reg.hit;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	for (genvar g = 0; g < SENSE_W; g++) begin : gChk
		a_sense_two_edges : assert property (
			st_reg.hit[g] |-> $past(st_reg.s2[g], 1) &&
				$past(st_reg.s2[g], 2))
			else $error("sense hit without two high samples");
		a_sense_min_width : assert property (
			st_reg.hit[g] |-> $past(st_reg.s2[g], 3) &&
				$past(st_reg.s2[g], 4))
			else $error("sense hit before 160 ns of high");
	end

endmodule : msc_sense_filter

// *** verification/msc_far_model.sv ***
// far-side model: two user sense sources and one cascaded peer
// assumes its tasks are called by the bench right after a rising edge
`timescale 1ns/1ns
module msc_far_model
	import msc_pkg::*;
(
	input  wire logic               sys_clk,
	input  wire logic               crOe,
	input  wire logic               crOut,
	output logic      [SENSE_W-1:0] senseIn,
	output logic                    startDelim,
	output logic                    chainStart,
	output logic                    crIn
);
	logic peerPull;

	// ********************************
	// shared ready wire
	// ********************************
	// open drain with pull-up: high only once nobody pulls low
	assign crIn = ~((crOe & ~crOut) | peerPull);

	initial begin
		senseIn = '0;
		startDelim = 1'b0;
		peerPull = 1'b1;
	end

	// start after release
	// peer watches the whole wire, not only its own release
	always @(posedge sys_clk) begin
		chainStart <= crIn & ~peerPull;
	end

	// ********************************
	// stimulus tasks
	// ********************************
	task automatic pulse_sense(input int idx, input int len);
		senseIn[idx] <= 1'b1;
		repeat (len) @(posedge sys_clk);
		senseIn[idx] <= 1'b0;
	endtask : pulse_sense

	task automatic send_delim();
		startDelim <= 1'b1;
		@(posedge sys_clk);
		startDelim <= 1'b0;
	endtask : send_delim

	task automatic set_peer(input logic pull);
		peerPull <= pull;
	endtask : set_peer
endmodule : msc_far_model

// *** verification/test_msc_misc_top.sv ***
// self-checking bench of the miscellaneous block
// assumes msc_far_model stands for the user logic and the peer device
`timescale 1ns/1ns
module test_msc_misc_top;
	import msc_pkg::*;
	logic              sys_clk, rst_n, wrEn, rdEn, rdSeen;
	logic [ADDR_W-1:0] regAddr;
	logic [DATA_W-1:0] wrData, rdData, upr, msk, outs;
	logic [SENSE_W-1:0] senseIn;
	logic              enableOut0, enableOut1, runMode, chainMode;
	logic              startDelim, chainStart, crIn, crOut, crOe, irq;
	logic [DATA_W-1:0] expQ[$];
	logic [ADDR_W-1:0] addrs[6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'hf};
	int                mismatches, checks, r;

	assign outs = {1'b0, enableOut1, enableOut0, runMode, chainMode,
		crOut, crOe, irq};

	msc_misc_top i_msc_misc_top (.sys_clk(sys_clk), .rst_n(rst_n),
		.regAddr(regAddr), .wrData(wrData), .wrEn(wrEn), .rdEn(rdEn),
		.rdData(rdData), .senseIn(senseIn), .enableOut0(enableOut0),
		.enableOut1(enableOut1), .runMode(runMode), .chainMode(chainMode),
		.startDelim(startDelim), .chainStart(chainStart), .crIn(crIn),
		.crOut(crOut), .crOe(crOe), .irq(irq));

	msc_far_model i_msc_far_model (.sys_clk(sys_clk), .crOe(crOe),
		.crOut(crOut), .senseIn(senseIn), .startDelim(startDelim),
		.chainStart(chainStart), .crIn(crIn));

	// ********************************
	// helpers
	// ********************************
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic finish_test();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : finish_test

	// checks run 1 ns after the last edge so they see settled outputs
	task automatic look(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : look

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		regAddr <= a;
		wrData <= d;
		wrEn <= 1'b1;
		@(posedge sys_clk);
		wrEn <= 1'b0;
	endtask : wr

	task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] e);
		@(posedge sys_clk);
		regAddr <= a;
		rdEn <= 1'b1;
		expQ.push_back(e);
		@(posedge sys_clk);
		rdEn <= 1'b0;
	endtask : rd

	// read data stands only in the cycle after the strobe
	always @(posedge sys_clk) begin
		if (rdSeen)
			check(rdData, expQ.pop_front());
		rdSeen <= rdEn;
	end

	initial begin
		repeat (3000) @(posedge sys_clk);
		mismatches++;
		finish_test();
	end

	// ********************************
	// scenarios
	// ********************************
	initial begin
		rst_n = 1'b0;
		wrEn = 1'b0;
		rdEn = 1'b0;
		rdSeen = 1'b0;
		regAddr = '0;
		wrData = '0;
		void'($urandom(32'hfcdec0a1));
		look(11);
		check(outs, 8'h02);
		@(posedge sys_clk);
		rst_n <= 1'b1;
		look(RST_WAIT_CYC);
		foreach (addrs[i])
			rd(addrs[i], 8'h00);
		wr(OFF_INT_EN, 8'h0f);
		r = $urandom % 4;
		for (int i = 0; i < 4; i++) begin
			upr = 8'(((i + r) % 4) << UPR_EN0);
			wr(OFF_UPR, upr);
			look(2);
			check(outs, {1'b0, upr[3], upr[2], 5'b00010});
			rd(OFF_UPR, upr);
		end
		for (int s = 0; s < SENSE_W; s++) begin
			msk = 8'(1 << s);
			@(posedge sys_clk);
			i_msc_far_model.pulse_sense(s, SENSE_CYC - 1);
			look(10);
			rd(OFF_UPR, upr);
			@(posedge sys_clk);
			i_msc_far_model.pulse_sense(s, SENSE_CYC);
			look(10);
			check({7'h0, irq}, 8'h01);
			rd(OFF_UPR, upr | msk);
			rd(OFF_INT_STAT, msk);
			wr(OFF_UPR, upr | msk);
			wr(OFF_INT_CLR, msk);
			look(2);
			check({7'h0, irq}, 8'h00);
			rd(OFF_UPR, upr);
		end
		@(posedge sys_clk);
		i_msc_far_model.send_delim();
		look(2);
		check(outs, {1'b0, upr[3], upr[2], 5'b00010});
		wr(OFF_MODE, 8'h03);
		look(2);
		check(outs, {1'b0, upr[3], upr[2], 5'b11010});
		@(posedge sys_clk);
		i_msc_far_model.send_delim();
		look(2);
		check(outs, {1'b0, upr[3], upr[2], 5'b11001});
		rd(OFF_MODE, 8'h07);
		@(posedge sys_clk);
		i_msc_far_model.set_peer(1'b0);
		look(10);
		rd(OFF_MODE, 8'h87);
		rd(OFF_INT_STAT, 8'h0c);
		wr(OFF_MODE, 8'h01);
		look(2);
		check(outs, {1'b0, upr[3], upr[2], 5'b10011});
		look(6);
		wr(OFF_INT_CLR, 8'h0c);
		rd(OFF_INT_STAT, 8'h00);
		@(posedge sys_clk);
		rst_n <= 1'b0;
		look(RST_MIN_CYC);
		check(outs, 8'h02);
		@(posedge sys_clk);
		rst_n <= 1'b1;
		rd(OFF_UPR, 8'h00);
		rd(OFF_MODE, 8'h00);
		look(3);
		finish_test();
	end
endmodule : test_msc_misc_top
